// ==== verilog/eplw_consts.svh ====
// constants of the eeprom page latch writer: offsets, fields, resets, timing
// assumes a 100 MHz core clock and a 32-bit AXI4-Lite register port
`ifndef EPLW_CONSTS_SVH
`define EPLW_CONSTS_SVH

`define EPLW_EE_FIRST 16'h0000
`define EPLW_EE_LAST 16'h07ff

`define EPLW_OFS_CTL 12'h000
`define EPLW_OFS_STAT 12'h004
`define EPLW_OFS_MASK 12'h008

`define EPLW_CTL_BUSY 0
`define EPLW_CTL_EN 1
`define EPLW_CTL_PV 2
`define EPLW_CTL_ROW_LSB 4

`define EPLW_EV_DONE 0
`define EPLW_EV_ABORT 1
`define EPLW_EV_DISCARD 2

`define EPLW_SEQ_FIRST 8'h50
`define EPLW_SEQ_SECOND 8'ha0
`define EPLW_BLOCKED_DATA 8'hff

`define EPLW_MASK_RST 3'h0
`define EPLW_RESP_OKAY 2'h0
`define EPLW_RESP_SLVERR 2'h2

`define EPLW_CLK_PERIOD_NS 10
`define EPLW_PROG_TIME_NS 10000000
`define EPLW_PROG_CYCLES (`EPLW_PROG_TIME_NS / `EPLW_CLK_PERIOD_NS)

`endif

// ==== verilog/eplw_pkg.sv ====
// types of the eeprom page latch writer
// assumes eplw_consts.svh for the offsets, fields and timing; the state encodings are set here
`default_nettype none
package eplw_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_WAIT = 2'h1,
    ST_SWEEP = 2'h3
  } eplw_state_t;

  typedef struct packed {
    logic awvalid;
    logic [11:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [11:0] araddr;
    logic rready;
  } eplw_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } eplw_axi_rsp_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] addr;
    logic [7:0] wdata;
  } eplw_cpu_req_t;

  typedef struct packed {
    logic ack;
    logic [7:0] rdata;
    logic eramSel;
  } eplw_cpu_rsp_t;

  typedef struct packed {
    logic enable;
    logic armed;
    logic busy;
    eplw_state_t state;
    logic [31:0] progCnt;
    logic [6:0] sweepCol;
    logic [127:0] marks;
    logic pageValid;
    logic [3:0] pageRow;
    logic xAck;
    logic [7:0] xRdata;
    logic [2:0] status;
    logic [2:0] mask;
    logic awHeld;
    logic [11:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
  } eplw_regs_t;

endpackage : eplw_pkg

`default_nettype wire

// ==== verilog/eplw_writer.sv ====
// eeprom page latch writer: 2-Kbyte data eeprom behind the cpu data port
// assumes one 100 MHz clock, synchronous active-low reset, AXI4-Lite slave
`timescale 1ns/1ps
`include "eplw_consts.svh"
`default_nettype none

module eplw_writer #(
  parameter int PROG_CYCLES = `EPLW_PROG_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register port
  input wire eplw_pkg::eplw_axi_req_t axiReq,
  output wire eplw_pkg::eplw_axi_rsp_t axiRsp,
  // cpu external data port
  input wire eplw_pkg::eplw_cpu_req_t cpuReq,
  input wire logic otherInstr,
  output wire eplw_pkg::eplw_cpu_rsp_t cpuRsp,
  // interrupt
  output wire logic irq
);
  import eplw_pkg::*;

  localparam logic [31:0] PROG_LAST = 32'(PROG_CYCLES - 1);

  function automatic logic inEe(input logic [15:0] a);
    return (a >= `EPLW_EE_FIRST) && (a <= `EPLW_EE_LAST);
  endfunction : inEe

  // 0 control, 1 status, 2 mask, 3 unmapped
  function automatic logic [1:0] regSel(input logic [11:0] a);
    logic [11:0] w;
    w = {a[11:2], 2'h0};
    if (w == `EPLW_OFS_CTL) return 2'h0;
    else if (w == `EPLW_OFS_STAT) return 2'h1;
    else if (w == `EPLW_OFS_MASK) return 2'h2;
    else return 2'h3;
  endfunction : regSel

  eplw_regs_t s_q;
  eplw_regs_t s_d;
  logic [7:0] eeMem [0:2047];
  logic [7:0] colData [0:127];
  logic latchWe;
  logic memWe;
  logic markClrAll;
  logic ctlWr;
  logic startProg;
  logic eeHit;
  logic [2:0] ev;
  logic [3:0] cpuRow;
  logic [6:0] cpuCol;
  logic [7:0] memRd;
  logic [7:0] ctlByte;
  logic statRd;

  assign cpuRow = cpuReq.addr[10:7];
  assign cpuCol = cpuReq.addr[6:0];
  assign eeHit = s_q.enable && inEe(cpuReq.addr);
  assign memRd = eeMem[cpuReq.addr[10:0]];
  assign ctlByte = s_q.wData[7:0];

  always_comb begin
    s_d = s_q;
    latchWe = 1'b0;
    memWe = 1'b0;
    markClrAll = 1'b0;
    ctlWr = 1'b0;
    statRd = 1'b0;
    startProg = 1'b0;
    ev = 3'h0;
    s_d.xAck = 1'b0;

    // cpu accesses in the eeprom window
    if (cpuReq.valid && eeHit) begin
      s_d.xAck = 1'b1;
      if (cpuReq.write) begin
        if (!s_q.busy) begin
          if (!s_q.pageValid || s_q.pageRow == cpuRow) begin
            latchWe = 1'b1;
            s_d.pageValid = 1'b1;
            s_d.pageRow = cpuRow;
            s_d.marks[cpuCol] = 1'b1;
          end else begin
            ev[`EPLW_EV_DISCARD] = 1'b1;
          end
        end
      end else begin
        s_d.xRdata = s_q.busy ? `EPLW_BLOCKED_DATA : memRd;
      end
    end

    // programming sequence
    unique case (s_q.state)
      ST_IDLE: begin
      end
      ST_WAIT: begin
        if (s_q.progCnt == 32'h0) begin
          s_d.state = ST_SWEEP;
          s_d.sweepCol = 7'h0;
        end else begin
          s_d.progCnt = s_q.progCnt - 32'h1;
        end
      end
      ST_SWEEP: begin
        memWe = s_q.marks[s_q.sweepCol];
        s_d.sweepCol = s_q.sweepCol + 7'h1;
        if (&s_q.sweepCol) begin
          s_d.state = ST_IDLE;
          s_d.busy = 1'b0;
          markClrAll = 1'b1;
          s_d.marks = '0;
          s_d.pageValid = 1'b0;
          ev[`EPLW_EV_DONE] = 1'b1;
        end
      end
      default: begin
        s_d.state = ST_IDLE;
      end
    endcase

    // register writes
    if (axiReq.awvalid && !s_q.awHeld) begin
      s_d.awHeld = 1'b1;
      s_d.awAddr = axiReq.awaddr;
    end
    if (axiReq.wvalid && !s_q.wHeld) begin
      s_d.wHeld = 1'b1;
      s_d.wData = axiReq.wdata;
      s_d.wStrb = axiReq.wstrb;
    end
    if (s_q.bValid && axiReq.bready) begin
      s_d.bValid = 1'b0;
    end
    if (s_q.awHeld && s_q.wHeld && !s_q.bValid) begin
      s_d.awHeld = 1'b0;
      s_d.wHeld = 1'b0;
      s_d.bValid = 1'b1;
      s_d.bResp = `EPLW_RESP_OKAY;
      unique case (regSel(s_q.awAddr))
        2'h0: begin
          if (s_q.wStrb[0]) begin
            ctlWr = 1'b1;
            s_d.enable = ctlByte[`EPLW_CTL_EN];
          end
        end
        2'h2: begin
          if (s_q.wStrb[0]) begin
            s_d.mask = s_q.wData[2:0];
          end
        end
        2'h1: begin
        end
        2'h3: begin
          s_d.bResp = `EPLW_RESP_SLVERR;
        end
      endcase
    end

    // launch sequence
    if (ctlWr) begin
      if (ctlByte == `EPLW_SEQ_FIRST) begin
        s_d.armed = 1'b1;
      end else begin
        s_d.armed = 1'b0;
        if (ctlByte == `EPLW_SEQ_SECOND && s_q.armed && !s_q.busy) begin
          startProg = 1'b1;
        end else if (s_q.armed) begin
          ev[`EPLW_EV_ABORT] = 1'b1;
        end
      end
    end else if (otherInstr && s_q.armed) begin
      s_d.armed = 1'b0;
      ev[`EPLW_EV_ABORT] = 1'b1;
    end
    if (startProg) begin
      s_d.busy = 1'b1;
      s_d.state = ST_WAIT;
      s_d.progCnt = PROG_LAST;
    end

    // register reads; status clears on read, new events win
    if (s_q.rValid && axiReq.rready) begin
      s_d.rValid = 1'b0;
    end
    s_d.status = s_q.status | ev;
    if (axiReq.arvalid && !s_q.rValid) begin
      s_d.rValid = 1'b1;
      s_d.rResp = `EPLW_RESP_OKAY;
      s_d.rData = 32'h0;
      unique case (regSel(axiReq.araddr))
        2'h0: begin
          s_d.rData[`EPLW_CTL_BUSY] = s_q.busy;
          s_d.rData[`EPLW_CTL_EN] = s_q.enable;
          s_d.rData[`EPLW_CTL_PV] = s_q.pageValid;
          s_d.rData[`EPLW_CTL_ROW_LSB +: 4] = s_q.pageRow;
        end
        2'h1: begin
          s_d.rData[2:0] = s_q.status;
          statRd = 1'b1;
          s_d.status = ev;
        end
        2'h2: begin
          s_d.rData[2:0] = s_q.mask;
        end
        2'h3: begin
          s_d.rResp = `EPLW_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_q <= '0;
      s_q.mask <= `EPLW_MASK_RST;
    end else begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge clk) begin
    if (latchWe) begin
      colData[cpuCol] <= cpuReq.wdata;
    end
    if (memWe) begin
      eeMem[{s_q.pageRow, s_q.sweepCol}] <= colData[s_q.sweepCol];
    end
  end

  assign axiRsp.awready = !s_q.awHeld;
  assign axiRsp.wready = !s_q.wHeld;
  assign axiRsp.bvalid = s_q.bValid;
  assign axiRsp.bresp = s_q.bResp;
  assign axiRsp.arready = !s_q.rValid;
  assign axiRsp.rvalid = s_q.rValid;
  assign axiRsp.rdata = s_q.rData;
  assign axiRsp.rresp = s_q.rResp;
  assign cpuRsp.ack = s_q.xAck;
  assign cpuRsp.rdata = s_q.xRdata;
  assign cpuRsp.eramSel = cpuReq.valid && !s_q.enable
    && inEe(cpuReq.addr);
  assign irq = |(s_q.status & s_q.mask);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_launch_busy: assert property (startProg |=> s_q.busy
    && s_q.state == ST_WAIT) else $error("launch did not set busy");
  a_abort_between: assert property (otherInstr && s_q.armed && !ctlWr
    |=> !s_q.armed ##1 !s_q.busy) else $error("launch not aborted");
  a_read_blocked: assert property (cpuReq.valid && !cpuReq.write
    && eeHit && s_q.busy |=> cpuRsp.ack
    && cpuRsp.rdata == `EPLW_BLOCKED_DATA) else $error("read not blocked");
  a_read_data: assert property (cpuReq.valid && !cpuReq.write
    && eeHit && !s_q.busy |=> cpuRsp.ack
    && cpuRsp.rdata == $past(memRd)) else $error("wrong eeprom data");
  a_marker_set: assert property (latchWe |=> s_q.marks[$past(cpuCol)]
    && s_q.pageValid) else $error("marker not set");
  a_row_done: assert property (s_q.state == ST_SWEEP
    && (&s_q.sweepCol) |=> s_q.marks == '0 && !s_q.busy
    && s_q.status[`EPLW_EV_DONE]) else $error("row end wrong");
  a_page_keep: assert property (cpuReq.valid && cpuReq.write
    && eeHit && s_q.pageValid && s_q.pageRow != cpuRow && !s_q.busy
    |=> $stable(s_q.pageRow) && s_q.status[`EPLW_EV_DISCARD])
    else $error("foreign page not discarded");
  a_expanded_ram_route: assert property (cpuReq.valid && !s_q.enable
    && inEe(cpuReq.addr) |-> cpuRsp.eramSel && !latchWe
    ##1 !cpuRsp.ack) else $error("disabled access reached eeprom");
  a_wait_sweep: assert property (s_q.state == ST_WAIT
    && s_q.progCnt == 32'h0 |=> s_q.state == ST_SWEEP
    && s_q.sweepCol == 7'h0 && s_q.busy) else $error("sweep not entered");
  a_busy_hold: assert property (s_q.busy && s_q.state != ST_SWEEP
    |=> s_q.busy) else $error("busy dropped early");

  // cpu side checks
  a_ack_only_hit: assert property (!(cpuReq.valid && eeHit)
    |=> !cpuRsp.ack) else $error("ack outside eeprom window");
  a_latch_enabled: assert property (latchWe
    |-> s_q.enable && !s_q.busy) else $error("latch write while off");
  a_row_capture: assert property (latchWe
    |=> s_q.pageRow == $past(cpuRow)) else $error("wrong page row");
  a_one_byte: assert property (latchWe
    |=> $countones(s_q.marks) <= $countones($past(s_q.marks)) + 1)
    else $error("more than one byte latched");
  a_foreign_drop: assert property (cpuReq.valid && cpuReq.write
    && eeHit && s_q.pageValid && s_q.pageRow != cpuRow |-> !latchWe)
    else $error("foreign page byte latched");
  a_busy_write_drop: assert property (cpuReq.valid && cpuReq.write
    && s_q.busy && !markClrAll |=> $stable(s_q.marks))
    else $error("write accepted while busy");

  // programming checks
  a_mem_sweep_only: assert property (s_q.state != ST_SWEEP
    |-> !memWe) else $error("array written outside sweep");
  a_wait_count: assert property (s_q.state == ST_WAIT
    && s_q.progCnt != 32'h0 |=> s_q.state == ST_WAIT
    && s_q.progCnt == $past(s_q.progCnt) - 32'h1)
    else $error("programming timer skipped");
  a_idle_free: assert property (s_q.state == ST_IDLE
    && !startProg |=> !s_q.busy) else $error("busy without programming");
  a_marks_clear: assert property (markClrAll
    |=> s_q.marks == '0 && !s_q.pageValid) else $error("markers left set");
  a_row_frozen: assert property (s_q.busy
    |=> $stable(s_q.pageRow)) else $error("page row moved while busy");
  a_launch_armed: assert property (startProg
    |-> s_q.armed && !s_q.busy) else $error("launch without arming");
  a_arm_first: assert property (ctlWr
    && ctlByte == `EPLW_SEQ_FIRST |=> s_q.armed)
    else $error("first value did not arm");

  // status and interrupt checks
  a_abort_status: assert property (otherInstr && s_q.armed && !ctlWr
    |=> s_q.status[`EPLW_EV_ABORT]) else $error("abort not flagged");
  a_status_sticky: assert property (s_q.status[`EPLW_EV_ABORT]
    && !statRd |=> s_q.status[`EPLW_EV_ABORT])
    else $error("abort flag lost");
  a_status_clear: assert property (statRd && ev == 3'h0
    |=> s_q.status == 3'h0) else $error("status not cleared by read");
  a_irq_done: assert property (s_q.status[`EPLW_EV_DONE]
    && s_q.mask[`EPLW_EV_DONE] |-> irq) else $error("done not signalled");

  // coverage
  c_prog_done: cover property (s_q.state == ST_SWEEP && (&s_q.sweepCol));
  c_abort: cover property (otherInstr && s_q.armed && !ctlWr);
  c_discard: cover property (ev[`EPLW_EV_DISCARD]);
  c_blocked_read: cover property (cpuReq.valid && !cpuReq.write
    && eeHit && s_q.busy);
  c_launch: cover property (startProg);

endmodule : eplw_writer

`default_nettype wire

// ==== verif/eplw_cpu_model.sv ====
// cpu model: issues external data move cycles and instruction pulses
// assumes the bench calls its tasks one at a time
`timescale 1ns/1ps
`default_nettype none
module eplw_cpu_model (
  // clock
  input wire logic clk,
  // cpu port
  output var eplw_pkg::eplw_cpu_req_t cpuReq,
  output var logic otherInstr,
  input wire eplw_pkg::eplw_cpu_rsp_t cpuRsp
);
  import eplw_pkg::*;
  initial begin
    cpuReq = '0;
    otherInstr = 1'b0;
  end
  // one byte per call, two cycles per call; enable picks eeprom or expanded ram, the address gives the page row
  task automatic access(input logic w, input logic [15:0] a,
    input logic [7:0] d, output logic sel, output logic ack,
    output logic [7:0] rd);
    @(posedge clk);
    cpuReq <= '{valid: 1'b1, write: w, addr: a, wdata: d};
    #1 sel = cpuRsp.eramSel;
    @(posedge clk);
    cpuReq <= '{valid: 1'b0, write: ~w, addr: ~a, wdata: ~d};
    #1 ack = cpuRsp.ack;
    rd = cpuRsp.rdata;
  endtask : access
  task automatic pulse();
    @(posedge clk);
    otherInstr <= 1'b1;
    @(posedge clk);
    otherInstr <= 1'b0;
  endtask : pulse
endmodule : eplw_cpu_model
`default_nettype wire

// ==== verif/eplw_writer_tb.sv ====
// testbench of the eeprom page latch writer
// assumes eplw_cpu_model on the cpu port, bench as AXI4-Lite master
`timescale 1ns/1ps
`include "eplw_consts.svh"
`default_nettype none
`define CHK(g, e, m) begin check_count++; if ((g) !== (e)) begin \
  mismatches++; $display("unexpected %0t %s", $time, m); end end
module eplw_writer_tb;
  import eplw_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  eplw_axi_req_t axiReq = '0;
  eplw_axi_rsp_t axiRsp;
  eplw_cpu_req_t cpuReq;
  eplw_cpu_rsp_t cpuRsp;
  logic otherInstr;
  logic irq;
  int mismatches = 0;
  int check_count = 0;
  int cyc = 0;
  logic [1:0] bRsp = 2'h3;
  logic [7:0] expMem [int];
  always #5 clk = ~clk;
  eplw_writer #(.PROG_CYCLES(20)) dut (.clk(clk), .resetn(resetn),
    .axiReq(axiReq), .axiRsp(axiRsp), .cpuReq(cpuReq),
    .otherInstr(otherInstr), .cpuRsp(cpuRsp), .irq(irq));
  eplw_cpu_model cpu (.clk(clk), .cpuReq(cpuReq),
    .otherInstr(otherInstr), .cpuRsp(cpuRsp));
  task automatic print_verdict();
    if (mismatches == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  function automatic logic [7:0] ctlExp(input logic en, input logic pv,
    input logic [3:0] row);
    logic [7:0] w;
    w = 8'h0;
    w[`EPLW_CTL_EN] = en;
    w[`EPLW_CTL_PV] = pv;
    w[`EPLW_CTL_ROW_LSB +: 4] = row;
    return w;
  endfunction : ctlExp
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      print_verdict();
    end
  end
  task automatic axiWr(input logic [11:0] a, input logic [31:0] d);
    logic a1, w1, b1;
    bit done;
    done = 0;
    @(posedge clk);
    axiReq.awvalid <= 1'b1;
    axiReq.awaddr <= a;
    axiReq.wvalid <= 1'b1;
    axiReq.wdata <= d;
    axiReq.wstrb <= 4'hf;
    axiReq.bready <= 1'b1;
    while (!done) begin
      @(negedge clk);
      a1 = axiRsp.awready;
      w1 = axiRsp.wready;
      b1 = axiRsp.bvalid;
      bRsp = axiRsp.bresp;
      @(posedge clk);
      if (a1) axiReq.awvalid <= 1'b0;
      if (w1) axiReq.wvalid <= 1'b0;
      if (b1) begin
        axiReq.bready <= 1'b0;
        done = 1;
      end
    end
  endtask : axiWr
  task automatic axiRd(input logic [11:0] a, output logic [31:0] d,
    output logic [1:0] r);
    logic ar1, rv1;
    bit done;
    done = 0;
    @(posedge clk);
    axiReq.arvalid <= 1'b1;
    axiReq.araddr <= a;
    axiReq.rready <= 1'b1;
    while (!done) begin
      @(negedge clk);
      ar1 = axiRsp.arready;
      rv1 = axiRsp.rvalid;
      d = axiRsp.rdata;
      r = axiRsp.rresp;
      @(posedge clk);
      if (ar1) axiReq.arvalid <= 1'b0;
      if (rv1) begin
        axiReq.rready <= 1'b0;
        done = 1;
      end
    end
  endtask : axiRd
  task automatic prog(input logic [3:0] row, input int n);
    logic [15:0] a;
    logic [7:0] d, rd;
    logic s, k;
    logic [31:0] v;
    logic [1:0] r;
    for (int i = 0; i < n; i++) begin
      a = {5'h0, row, (n == 128) ? 7'(i) : 7'($urandom)};
      d = 8'($urandom);
      cpu.access(1'b1, a, d, s, k, rd);
      `CHK(k, 1'b1, "latch write ack")
      expMem[a] = d;
    end
    cpu.access(1'b1, {5'h0, row ^ 4'h1, 7'h05}, 8'h3c, s, k, rd);
    axiRd(`EPLW_OFS_CTL, v, r);
    `CHK(v[7:0], ctlExp(1'b1, 1'b1, row), "latched row")
    axiWr(`EPLW_OFS_CTL, 32'h50);
    axiWr(`EPLW_OFS_CTL, 32'ha0);
    axiWr(`EPLW_OFS_CTL, 32'h2);
    cpu.access(1'b0, a, 8'h0, s, k, rd);
    `CHK(rd, `EPLW_BLOCKED_DATA, "read while busy")
    cpu.access(1'b1, a, ~expMem[a], s, k, rd);
    `CHK(k, 1'b1, "write while busy acked")
    axiRd(`EPLW_OFS_CTL, v, r);
    `CHK(v[0], 1'b1, "busy after launch")
    while (v[0] === 1'b1) axiRd(`EPLW_OFS_CTL, v, r);
    `CHK(v[2:0], 3'b010, "markers cleared")
    axiRd(`EPLW_OFS_STAT, v, r);
    `CHK(v[2:0], 3'b101, "done and discard")
  endtask : prog
  initial begin
    logic [31:0] v;
    logic [1:0] r;
    logic s, k;
    logic [7:0] rd;
    void'($urandom(32'hb020));
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      axiRd(12'(4 * i), v, r);
      `CHK(v, 32'h0, "reset value")
    end
    axiRd(12'h00c, v, r);
    `CHK({r, v}, {`EPLW_RESP_SLVERR, 32'h0}, "unmapped read")
    axiWr(12'h00c, 32'h5a);
    `CHK(bRsp, `EPLW_RESP_SLVERR, "unmapped write")
    cpu.access(1'b1, 16'h07ff, 8'h11, s, k, rd);
    `CHK({s, k}, 2'b10, "expanded ram access")
    axiWr(`EPLW_OFS_CTL, 32'h2);
    `CHK(bRsp, `EPLW_RESP_OKAY, "control write response")
    cpu.access(1'b0, 16'h0800, 8'h0, s, k, rd);
    `CHK({s, k}, 2'b00, "outside window")
    for (int c = 0; c < 2; c++) begin
      axiWr(`EPLW_OFS_MASK, c ? 32'h7 : 32'h0);
      axiRd(`EPLW_OFS_MASK, v, r);
      `CHK(v, c ? 32'h7 : 32'h0, "mask readback")
      axiWr(`EPLW_OFS_CTL, 32'h50);
      if (c) cpu.pulse();
      else axiWr(`EPLW_OFS_CTL, 32'h2);
      axiWr(`EPLW_OFS_CTL, 32'ha0);
      `CHK(irq, 1'(c), "abort interrupt")
      axiRd(`EPLW_OFS_CTL, v, r);
      `CHK(v[0], 1'b0, "no launch")
      axiRd(`EPLW_OFS_STAT, v, r);
      `CHK(v[2:0], 3'b010, "abort status")
      `CHK(irq, 1'b0, "status cleared by read")
      axiWr(`EPLW_OFS_CTL, 32'h2);
    end
    v[3:0] = 4'($urandom);
    prog(v[3:0], 128);
    prog(v[3:0], 4);
    foreach (expMem[a]) begin
      cpu.access(1'b0, 16'(a), 8'h0, s, k, rd);
      `CHK({k, rd}, {1'b1, expMem[a]}, "programmed byte")
    end
    print_verdict();
  end
endmodule : eplw_writer_tb
`undef CHK
`default_nettype wire
